/* design/ppc_port_power_pin_control.v */
/*
 Port power pin control: APB slave with direction, output, input and
 pull-up registers for port power pins 7 to 1, and power select
 registers for ports 1 and 2.
 Assumes an APB master on pclk, pins asynchronous to pclk, and power
 requests from hub logic on pclk.
*/
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "ppc_port_power_regs.vh"
module ppc_port_power_pin_control #(
	parameter ADDR_W = 16,
	parameter NUM_PINS = 7
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [NUM_PINS:1] port_power_pin_in,
	output wire [NUM_PINS:1] port_power_pin_out,
	output wire [NUM_PINS:1] port_power_pin_oe,
	output wire [NUM_PINS:1] power_pin_pullup_bits,
	input wire [2:1] overcurrent_sense_n,
	input wire [2:1] usb2_port_power,
	input wire [2:1] usb3_port_power,
	input wire [2:1] gpio_port_power,
	output wire [2:1] port_power_on,
	output wire [2:1] port_disabled,
	output wire [2:1] port_fixed_attach,
	output wire [2:1] port_shared_pin,
	output wire [2:1] port_overcurrent
);

	// ==========================================
	// Byte addresses from register indices
	localparam [ADDR_W-1:0] ADDR_DIR = {`PPC_IDX_DIR, 2'b00};
	localparam [ADDR_W-1:0] ADDR_OUT = {`PPC_IDX_OUT, 2'b00};
	localparam [ADDR_W-1:0] ADDR_IN = {`PPC_IDX_IN, 2'b00};
	localparam [ADDR_W-1:0] ADDR_PU = {`PPC_IDX_PU, 2'b00};
	localparam [ADDR_W-1:0] ADDR_SEL1 = {`PPC_IDX_SEL1, 2'b00};
	localparam [ADDR_W-1:0] ADDR_SEL2 = {`PPC_IDX_SEL2, 2'b00};
	localparam [ADDR_W-1:0] ADDR_STAT = {`PPC_IDX_STAT, 2'b00};

	// ==========================================
	// Register storage
	reg [7:0] power_pin_direction_reg;
	reg [7:0] power_pin_out_reg;
	reg [7:0] power_pin_pullup_reg;
	reg [7:0] port1_source_select_reg;
	reg [7:0] port2_source_select_reg;
	reg [31:0] prdata_reg;
	reg [31:0] prdata_next;
	reg hit_next;

	wire [NUM_PINS:1] pin_sampled;
	wire [2:1] sense_sampled_n;
	wire [7:0] power_pin_in_reg;
	wire [7:0] status_byte;
	wire setup_phase;
	wire access_phase;
	wire write_strobe;
	wire [7:0] wbyte;

	// ==========================================
	// Pin and sense synchronisers
	// Pins are asynchronous; two stages keep metastability out
	ppc_sync #(
		.WIDTH(NUM_PINS)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(port_power_pin_in),
		.sync_out(pin_sampled)
	);

	ppc_sync #(
		.WIDTH(2)
	) u_sense_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(overcurrent_sense_n),
		.sync_out(sense_sampled_n)
	);

	// ==========================================
	// APB phase decode
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	// Zero wait states: read data is latched in setup
	assign pready = 1'b1;

	// Only the low byte holds data; lane 0 strobe gates writes
	assign write_strobe = access_phase & pwrite & pstrb[0];
	assign wbyte = pwdata[7:0];

	// ==========================================
	// Register decode and read mux, evaluated in setup
	always @* begin
		prdata_next = 32'h0000_0000;
		hit_next = 1'b1;
		if (paddr == ADDR_DIR) begin
			prdata_next[7:0] = power_pin_direction_reg;
		end else if (paddr == ADDR_OUT) begin
			prdata_next[7:0] = power_pin_out_reg;
		end else if (paddr == ADDR_IN) begin
			prdata_next[7:0] = power_pin_in_reg;
		end else if (paddr == ADDR_PU) begin
			prdata_next[7:0] = power_pin_pullup_reg;
		end else if (paddr == ADDR_SEL1) begin
			prdata_next[7:0] = port1_source_select_reg;
		end else if (paddr == ADDR_SEL2) begin
			prdata_next[7:0] = port2_source_select_reg;
		end else if (paddr == ADDR_STAT) begin
			prdata_next[7:0] = status_byte;
		end else begin
			hit_next = 1'b0;
		end
	end

	// Unmapped address: error in access, reads return zero
	reg hit_reg;
	assign pslverr = access_phase & ~hit_reg;

	// Read data and decode hit captured at setup edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			hit_reg <= 1'b0;
		end else if (setup_phase) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
			hit_reg <= hit_next;
		end
	end

	assign prdata = prdata_reg;

	// ==========================================
	// Register writes
	// Bit 0 and select bit 6 are masked so they read as zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_pin_direction_reg <= `PPC_RST_DIR;
			power_pin_out_reg <= `PPC_RST_OUT;
			power_pin_pullup_reg <= `PPC_RST_PU;
			port1_source_select_reg <= `PPC_RST_SEL;
			port2_source_select_reg <= `PPC_RST_SEL;
		end else if (write_strobe) begin
			if (paddr == ADDR_DIR) begin
				power_pin_direction_reg <= wbyte & `PPC_PIN_MASK;
			end else if (paddr == ADDR_OUT) begin
				power_pin_out_reg <= wbyte & `PPC_PIN_MASK;
			end else if (paddr == ADDR_PU) begin
				power_pin_pullup_reg <= wbyte & `PPC_PIN_MASK;
			end else if (paddr == ADDR_SEL1) begin
				port1_source_select_reg <= wbyte & `PPC_SEL_MASK;
			end else if (paddr == ADDR_SEL2) begin
				port2_source_select_reg <= wbyte & `PPC_SEL_MASK;
			end
		end
	end

	// ==========================================
	// Per pin drive, enable, pull-up and sampling
	genvar gi;
	generate
		for (gi = 1; gi <= NUM_PINS; gi = gi + 1) begin : g_pin
			// Bit position matches pin number
			assign port_power_pin_out[gi] = power_pin_out_reg[gi];
			// Direction one drives, zero leaves the pin an input
			assign port_power_pin_oe[gi] = power_pin_direction_reg[gi];
			assign power_pin_pullup_bits[gi] = power_pin_pullup_reg[gi];
			assign power_pin_in_reg[gi] = pin_sampled[gi];
		end
	endgenerate

	// Bit 0 of the input register is not a pin
	assign power_pin_in_reg[0] = 1'b0;

	// ==========================================
	// Power select decode for ports 1 and 2
	// Settings are assumed static once configured
	ppc_source_select u_port1_select (
		.select_byte(port1_source_select_reg),
		.usb2_power_on(usb2_port_power[1]),
		.usb3_power_on(usb3_port_power[1]),
		.gpio_power_on(gpio_port_power[1]),
		.shared_sense_n(pin_sampled[1]),
		.own_sense_n(sense_sampled_n[1]),
		.power_on(port_power_on[1]),
		.disabled(port_disabled[1]),
		.fixed_attach_flag(port_fixed_attach[1]),
		.shared_pin(port_shared_pin[1]),
		.overcurrent(port_overcurrent[1])
	);

	ppc_source_select u_port2_select (
		.select_byte(port2_source_select_reg),
		.usb2_power_on(usb2_port_power[2]),
		.usb3_power_on(usb3_port_power[2]),
		.gpio_power_on(gpio_port_power[2]),
		.shared_sense_n(pin_sampled[2]),
		.own_sense_n(sense_sampled_n[2]),
		.power_on(port_power_on[2]),
		.disabled(port_disabled[2]),
		.fixed_attach_flag(port_fixed_attach[2]),
		.shared_pin(port_shared_pin[2]),
		.overcurrent(port_overcurrent[2])
	);

	// ==========================================
	// Status byte: power state and over-current per port
	// Lets software see the decoded result, not just settings
	assign status_byte = {1'b0, port_overcurrent, 2'b00, port_power_on, 1'b0};

endmodule

/* design/ppc_port_power_regs.vh */
/*
 Register indices, field positions, reset values and power source
 codes of the port power pin control block.
 Assumes it is included by its bare name from the design files.
*/
`ifndef PPC_PORT_POWER_REGS_VH
`define PPC_PORT_POWER_REGS_VH

// ==========================================
// Register indices; byte address is four times the index
`define PPC_IDX_DIR 14'h0932
`define PPC_IDX_OUT 14'h0936
`define PPC_IDX_IN 14'h093a
`define PPC_IDX_PU 14'h093e
`define PPC_IDX_SEL1 14'h3c00
`define PPC_IDX_SEL2 14'h3c04
`define PPC_IDX_STAT 14'h3c40

// ==========================================
// Field positions
`define PPC_PIN_HI 7
`define PPC_PIN_LO 1
`define PPC_SEL_SHARED 7
`define PPC_SEL_RSVD 6
`define PPC_SEL_DISABLE 5
`define PPC_SEL_FIXED 4
`define PPC_SEL_CODE_HI 3
`define PPC_SEL_CODE_LO 0
`define PPC_STAT_ON_LO 1
`define PPC_STAT_OC_LO 5

// ==========================================
// Writable masks of the byte-wide registers
`define PPC_PIN_MASK 8'hfe
`define PPC_SEL_MASK 8'hbf

// ==========================================
// Reset values
`define PPC_RST_DIR 8'h00
`define PPC_RST_OUT 8'h00
`define PPC_RST_PU 8'h00
`define PPC_RST_SEL 8'h00

// ==========================================
// Power source codes
`define PPC_SRC_OFF 4'h0
`define PPC_SRC_USB2 4'h1
`define PPC_SRC_USB3 4'h2
`define PPC_SRC_EITHER 4'h3
`define PPC_SRC_GPIO 4'h4

`endif

/* design/ppc_sync.v */
/*
 Two flip-flop level synchroniser, width set by a parameter.
 Assumes the inputs are asynchronous levels from pins.
*/
`timescale 1ns/100ps
module ppc_sync #(
	parameter WIDTH = 7
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] stable_reg;

	// First stage feeds the second stage only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= {WIDTH{1'b0}};
			stable_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			stable_reg <= meta_reg;
		end
	end

	assign sync_out = stable_reg;
endmodule

/* design/ppc_source_select.v */
/*
 Decode of one port power select byte into the port's power state,
 disable, fixed attach, shared pin and over-current flags.
 Assumes all inputs are already on the pclk domain.
*/
`timescale 1ns/100ps
`include "ppc_port_power_regs.vh"
module ppc_source_select (
	input wire [7:0] select_byte,
	input wire usb2_power_on,
	input wire usb3_power_on,
	input wire gpio_power_on,
	input wire shared_sense_n,
	input wire own_sense_n,
	output reg power_on,
	output wire disabled,
	output wire fixed_attach_flag,
	output wire shared_pin,
	output wire overcurrent
);
	wire [3:0] power_source_code;

	assign power_source_code = select_byte[`PPC_SEL_CODE_HI:`PPC_SEL_CODE_LO];
	assign disabled = select_byte[`PPC_SEL_DISABLE];
	assign fixed_attach_flag = select_byte[`PPC_SEL_FIXED];
	assign shared_pin = select_byte[`PPC_SEL_SHARED];

	// Sense taken from the power pin itself in shared mode
	assign overcurrent = shared_pin ? ~shared_sense_n : ~own_sense_n;

	// Source decode; a disabled port never gets power
	always @* begin
		power_on = 1'b0;
		if (!disabled) begin
			case (power_source_code)
				`PPC_SRC_OFF: power_on = 1'b0;
				`PPC_SRC_USB2: power_on = usb2_power_on;
				`PPC_SRC_USB3: power_on = usb3_power_on;
				`PPC_SRC_EITHER: power_on = usb2_power_on | usb3_power_on;
				`PPC_SRC_GPIO: power_on = gpio_power_on;
				// Reserved codes fail safe to off
				default: power_on = 1'b0;
			endcase
		end
	end
endmodule

/* testbench/ppc_port_power_monitor.sv */
/* Port checks of the port power pin control block.
 Assumes it is bound to every instance of the block. */
`timescale 1ns/100ps
`include "ppc_port_power_regs.vh"
module ppc_port_power_monitor #(
	parameter ADDR_W = 16,
	parameter NUM_PINS = 7
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [NUM_PINS:1] port_power_pin_out,
	input wire [NUM_PINS:1] port_power_pin_oe,
	input wire [NUM_PINS:1] power_pin_pullup_bits,
	input wire [2:1] port_power_on,
	input wire [2:1] port_disabled,
	input wire [2:1] port_fixed_attach,
	input wire [2:1] port_shared_pin
);
// ======
// Byte addresses are four times the register index
localparam [15:0] A_DIR = {`PPC_IDX_DIR, 2'b00};
localparam [15:0] A_OUT = {`PPC_IDX_OUT, 2'b00};
localparam [15:0] A_IN = {`PPC_IDX_IN, 2'b00};
localparam [15:0] A_PU = {`PPC_IDX_PU, 2'b00};
localparam [15:0] A_S1 = {`PPC_IDX_SEL1, 2'b00};
localparam [15:0] A_S2 = {`PPC_IDX_SEL2, 2'b00};
localparam [15:0] A_ST = {`PPC_IDX_STAT, 2'b00};
// Decoded transfers; a write needs strobe lane 0
wire acc = psel & penable;
wire wr = acc & pwrite & pstrb[0];
wire hit = paddr == A_DIR || paddr == A_OUT || paddr == A_IN || paddr == A_PU || paddr == A_S1 || paddr == A_S2 || paddr == A_ST;
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
// ======
// Properties
a_ready_high: assert property (pready) else $error("pready low");
a_map_err: assert property (acc |-> pslverr == !hit) else $error("pslverr wrong");
a_out_write: assert property (wr && paddr == A_OUT |=> port_power_pin_out == $past(pwdata[7:1])) else $error("out bad");
a_out_hold: assert property (!(wr && paddr == A_OUT) |=> $stable(port_power_pin_out)) else $error("out moved");
a_pullup_write: assert property (wr && paddr == A_PU |=> power_pin_pullup_bits == $past(pwdata[7:1])) else $error("pu bad");
a_dir_write: assert property (wr && paddr == A_DIR |=> port_power_pin_oe == $past(pwdata[7:1])) else $error("oe bad");
a_sel_flags: assert property (wr && paddr == A_S1 |=> {port_shared_pin[1], port_disabled[1], port_fixed_attach[1]} == $past({pwdata[7], pwdata[5], pwdata[4]})) else $error("flags bad");
a_sel2_flags: assert property (wr && paddr == A_S2 |=> {port_shared_pin[2], port_disabled[2], port_fixed_attach[2]} == $past({pwdata[7], pwdata[5], pwdata[4]})) else $error("flags2 bad");
a_disabled_off: assert property ((port_disabled & port_power_on) == 2'h0) else $error("disabled port on");
a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
a_bit0_zero: assert property (acc && !pwrite && paddr[15:8] == 8'h24 && paddr[7:4] != 4'hc |-> !prdata[0]) else $error("bit0 set");
c_sel_write: cover property (wr && paddr == A_S1);
c_unmapped: cover property (acc && pslverr);
c_power_on: cover property (port_power_on != 2'h0);
endmodule
bind ppc_port_power_pin_control ppc_port_power_monitor #(.ADDR_W(ADDR_W), .NUM_PINS(NUM_PINS)) u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port_power_pin_out(port_power_pin_out), .port_power_pin_oe(port_power_pin_oe),
	.power_pin_pullup_bits(power_pin_pullup_bits), .port_power_on(port_power_on),
	.port_disabled(port_disabled), .port_fixed_attach(port_fixed_attach), .port_shared_pin(port_shared_pin));

/* testbench/ppc_pin_partner.sv */
/* Model of the external power switches and pads on pins 7 to 1.
 Assumes the bench gives the level an undriven, unpulled pad floats to. */
`timescale 1ns/100ps
module ppc_pin_partner (
	input wire [7:1] drive,
	input wire [7:1] drive_en,
	input wire [7:1] pull_en,
	input wire [7:1] float_lvl,
	output wire [7:1] pad
);
// ======
// Driver wins, then pull-up; a bare pad floats to a changing level
assign pad = (drive_en & drive) | (~drive_en & pull_en) | (~drive_en & ~pull_en & float_lvl);
endmodule

/* testbench/test_port_power_pin_control.sv */
/* Random self-checking bench of the port power pin control block.
 Assumes the design, pad model and monitor are compiled before it. */
`timescale 1ns/100ps
`include "ppc_port_power_regs.vh"
module test_port_power_pin_control;
localparam [95:0] AM = {`PPC_IDX_SEL2, 2'b00, `PPC_IDX_SEL1, 2'b00, `PPC_IDX_PU, 2'b00,
	`PPC_IDX_IN, 2'b00, `PPC_IDX_OUT, 2'b00, `PPC_IDX_DIR, 2'b00};
reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
reg [15:0] paddr = 16'h0;
reg [31:0] pwdata = 32'h0, rnd = 32'h15c3bc59, rd;
reg [3:0] pstrb = 4'hf;
reg [7:1] flt = 7'h0;
reg [2:1] sense_n = 2'h3, u2 = 2'h0, u3 = 2'h0, gp = 2'h0;
reg [7:0] sel, lvl;
reg ep, eo;
wire [31:0] prdata;
wire pready, pslverr;
wire [7:1] pin, pout, poe, ppu;
wire [2:1] pon, poc, pdis, pfix, pshr;
integer n_mismatch = 0, samples_checked = 0, i, j, k;
// ======
// Clock, design and pad model
always #50 pclk = ~pclk;
ppc_port_power_pin_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .port_power_pin_in(pin), .port_power_pin_out(pout), .port_power_pin_oe(poe),
	.power_pin_pullup_bits(ppu), .overcurrent_sense_n(sense_n), .usb2_port_power(u2),
	.usb3_port_power(u3), .gpio_port_power(gp), .port_power_on(pon), .port_disabled(pdis),
	.port_fixed_attach(pfix), .port_shared_pin(pshr), .port_overcurrent(poc));
ppc_pin_partner pads (.drive(pout), .drive_en(poe), .pull_en(ppu), .float_lvl(flt), .pad(pin));
// ======
// Helpers
function [31:0] lfsr(input [31:0] s);
	lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// Expected power state; a disabled port stays off
function pw(input [7:0] s, input a, input b, input g);
	begin
		case (s[3:0])
			4'h1: pw = a;
			4'h2: pw = b;
			4'h3: pw = a | b;
			4'h4: pw = g;
			default: pw = 1'b0;
		endcase
		if (s[5]) pw = 1'b0;
	end
endfunction
task finish_test;
	begin
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	end
endtask
task chk(input string nm, input [31:0] s, input [31:0] x);
	begin
		samples_checked = samples_checked + 1;
		if (s !== x) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %s exp %h seen %h", nm, x, s);
		end
	end
endtask
// One APB transfer; waits on pready with a bounded count
task apb(input [15:0] a, input w, input [31:0] d, output [31:0] r, output e);
	integer n;
	begin
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n = n + 1;
		end
		if (pready !== 1'b1) begin
			n_mismatch = n_mismatch + 1;
			finish_test;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
endtask
// ======
// Main sequence
initial begin
	repeat (12) @(posedge pclk);
	presetn <= 1'b1;
	for (i = 0; i < 6; i = i + 1) begin
		apb(AM[16*i +: 16], 1'b0, 32'h0, rd, err);
		chk("reset", rd, 32'h0);
	end
	// Random pin registers; the pads resolve driver, pull-up and float
	for (i = 0; i < 8; i = i + 1) begin
		rnd = lfsr(rnd);
		flt <= rnd[31:25];
		apb(AM[15:0], 1'b1, rnd, rd, err);
		apb(AM[31:16], 1'b1, rnd >> 8, rd, err);
		apb(AM[63:48], 1'b1, rnd >> 16, rd, err);
		apb(AM[47:32], 1'b1, ~rnd, rd, err); // Input register must ignore this
		repeat (3) @(posedge pclk);
		chk("pin out", pout, rnd[15:9]);
		chk("pin oe", poe, rnd[7:1]);
		chk("pullup", ppu, rnd[23:17]);
		apb(AM[31:16], 1'b0, 32'h0, rd, err);
		chk("out reg", rd, rnd[15:8] & 8'hfe);
		lvl = {(rnd[7:1] & rnd[15:9]) | (~rnd[7:1] & rnd[23:17]) | (~rnd[7:1] & ~rnd[23:17] & rnd[31:25]), 1'b0};
		apb(AM[47:32], 1'b0, 32'h0, rd, err);
		chk("in reg", rd, lvl);
	end
	// Every defined source code on both ports, random flags and requests
	for (i = 0; i < 10; i = i + 1) begin
		rnd = lfsr(rnd);
		j = i % 5;
		k = i < 5 ? 1 : 2;
		sel = {rnd[7:6], rnd[5] & rnd[3], rnd[4], j[3:0]};
		// Requests idle while the port is reconfigured; defined codes only
		{u2, u3, gp} <= 6'h00;
		apb(AM[64+16*(k-1) +: 16], 1'b1, sel, rd, err);
		u2 <= rnd[9:8];
		u3 <= rnd[11:10];
		gp <= rnd[13:12];
		sense_n <= rnd[15:14];
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		ep = pw(sel, u2[k], u3[k], gp[k]);
		eo = sel[7] ? !pin[k] : !sense_n[k];
		chk("power on", pon[k], ep);
		chk("flags", {pshr[k], pdis[k], pfix[k]}, {sel[7], sel[5], sel[4]});
		chk("overcur", poc[k], eo);
		// Decoded state is also visible to software
		apb({`PPC_IDX_STAT, 2'b00}, 1'b0, 32'h0, rd, err);
		chk("stat on", rd[k], ep);
		chk("stat oc", rd[4+k], eo);
		apb(AM[64+16*(k-1) +: 16], 1'b0, 32'h0, rd, err);
		chk("select", rd, sel & 8'hbf);
	end
	// Unmapped address reads zero with an error
	apb(16'h0010, 1'b0, 32'h0, rd, err);
	chk("slverr", err, 1'b1);
	chk("bad rd", rd, 32'h0);
	// Lane 0 strobe low: the write is dropped without error
	apb(AM[31:16], 1'b1, 32'h0000_00aa, rd, err);
	pstrb <= 4'he;
	apb(AM[31:16], 1'b1, 32'h0000_0054, rd, err);
	chk("strb err", err, 1'b0);
	pstrb <= 4'hf;
	apb(AM[31:16], 1'b0, 32'h0, rd, err);
	chk("strb out", rd, 32'h0000_00aa);
	finish_test;
end
endmodule
